// ---- bench/core_activity_model.sv ----
// Purpose: stands in for the core bus activity and the comparator match logic
// Assumes: called from the bench right after a rising edge
// Notes: an idle event shows inverted fields so stale values cannot pass
module core_activity_model
(
	input wire logic clock,
	output logic [2:0] matchIn,
	output dbg_seq_pkg::bus_event_t busEvent
);
	timeunit 1ns;
	timeprecision 1ps;
	import dbg_seq_pkg::*;
	initial matchIn = 3'h0;
	initial busEvent = '0;
	task automatic pulseMatch(input logic [2:0] m);
		matchIn <= m;
		@(posedge clock);
		matchIn <= 3'h0;
	endtask : pulseMatch
	task automatic emit(input bus_event_t e);
		busEvent <= e;
		@(posedge clock);
		busEvent <= {1'b0, ~e[41:0]};
	endtask : emit
endmodule : core_activity_model

// ---- bench/debug_state1_sequencer_trace_checker.sv ----
// Purpose: port-level checks for the state1 sequencer and trace formatter
// Assumes: no control write lands in the cycle of a disarm pulse
// Notes: routing codes are not visible here, so the bench checks them
module debug_state1_sequencer_trace_checker
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic [2:0] matchIn,
	input wire logic [2:0] compEnable,
	input wire logic sessionDone,
	input wire logic breakNoTrace,
	input wire dbg_seq_pkg::bus_event_t busEvent,
	input wire dbg_seq_pkg::trace_row_t traceRow,
	input var dbg_seq_pkg::seq_state_t seqState
);
	timeunit 1ns;
	timeprecision 1ps;
	import dbg_seq_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_LEAVE_ONE: assert property (
		$past(seqState) == ST_ONE && seqState inside {ST_TWO, ST_THREE, ST_FINAL}
		|-> $past(|(matchIn & compEnable))) else $error("left state one without a match");
	AST_HOLD_LATER: assert property (
		seqState inside {ST_TWO, ST_THREE, ST_FINAL}
		|=> seqState == $past(seqState) || seqState == ST_IDLE) else $error("later state moved");
	AST_ENTER_ONE: assert property (
		seqState == ST_ONE && $past(seqState) != ST_ONE
		|-> $past(seqState) == ST_IDLE) else $error("state one entered from a busy state");
	AST_DISARM: assert property (
		(sessionDone || breakNoTrace) && seqState != ST_IDLE && !s_axi_awvalid && !s_axi_bvalid
		|-> ##[1:2] seqState == ST_IDLE) else $error("disarm pulse did not idle the sequencer");
	AST_ROW_CAUSE: assert property (
		traceRow.valid |-> $past(busEvent.valid)) else $error("trace row without a bus event");
	AST_WRITE_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	AST_READ_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
	AST_READ_WIDTH: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("read upper bits not zero");
	cover property ($past(seqState) == ST_ONE && seqState == ST_FINAL);
	cover property ($past(seqState) == ST_ONE && seqState == ST_TWO);
	cover property ($past(seqState) == ST_ONE && seqState == ST_THREE);
endmodule : debug_state1_sequencer_trace_checker

// ---- bench/debug_state1_sequencer_trace_tb.sv ----
// Purpose: self-checking bench for the state1 sequencer and trace formatter
// Assumes: one axi4-lite access at a time, inputs change at rising edges
// Notes: route entries pack code, enables, matches and expected state
module debug_state1_sequencer_trace_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dbg_seq_pkg::*;
	localparam logic [36:0] MASK_V = 37'h1000000000;
	localparam logic [36:0] MASK_A = 37'h13ffff0000;
	localparam logic [36:0] MASK_I = 37'h1fffff0000;
	logic clock = 1'b0, rst_n = 1'b0, sessionDone = 1'b0, breakNoTrace = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] wResp = 2'h3;
	logic [2:0] compEnable = 3'h7, matchIn;
	bus_event_t busEvent;
	trace_row_t traceRow;
	seq_state_t seqState;
	int errCount = 0, checks = 0;
	logic [15:0] route [24] = '{16'h0744, 16'h0611,
		16'h1723, 16'h1711, 16'h2742, 16'h3722, 16'h9713,
		16'h4712, 16'h4723, 16'h5734, 16'h5723, 16'h6752, 16'h6743,
		16'h7722, 16'h7712, 16'hd734, 16'hd722, 16'hd744,
		16'h8771, 16'ha771, 16'hb771, 16'hc771, 16'he771, 16'hf771};
	always #5 clock = ~clock;
	debug_state1_sequencer_trace debug_state1_sequencer_trace_inst (.clock(clock),
		.rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.matchIn(matchIn), .compEnable(compEnable), .sessionDone(sessionDone),
		.breakNoTrace(breakNoTrace), .busEvent(busEvent), .traceRow(traceRow),
		.seqState(seqState));
	core_activity_model core_activity_model_inst (.clock(clock), .matchIn(matchIn),
		.busEvent(busEvent));
	task automatic report(input string n, input logic [36:0] e, input logic [36:0] g);
		errCount++;
		$display("unexpected %s: expected %h, seen %h", n, e, g);
	endtask : report
	task automatic chkReg(input string n, input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e)
			report(n, {3'h0, e}, {3'h0, g});
	endtask : chkReg
	task automatic chkState(input seq_state_t e);
		checks++;
		if (seqState !== e)
			report("state", 37'(e), 37'(seqState));
	endtask : chkState
	task automatic chkRow(input trace_row_t e, input logic [36:0] m);
		checks++;
		if ((traceRow & m) !== (e & m))
			report("trace row", e, traceRow);
	endtask : chkRow
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		wResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWrite
	task automatic rdChk(input string n, input logic [11:0] a, input logic [33:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chkReg(n, e, {s_axi_rresp, s_axi_rdata});
	endtask : rdChk
	function automatic bus_event_t ev(input logic [17:0] a, input logic [7:0] f);
		return {1'b1, a, 16'h5a3c, f};
	endfunction : ev
	function automatic trace_row_t row(input logic [1:0] i, input logic [17:0] a);
		return {1'b1, i, a, 16'h5a3c};
	endfunction : row
	task automatic emitChk(input bus_event_t e, input trace_row_t r, input logic [36:0] m);
		core_activity_model_inst.emit(e);
		// the row launched at the edge above has settled by the next one
		@(posedge clock);
		chkRow(r, m);
	endtask : emitChk
	task automatic conclude;
		$display("checks %0d, errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial
	begin
		#50us;
		errCount++;
		conclude();
	end
	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rdChk("scr1 reset", SCR1_ADDR, {AXI_OKAY, 28'h0, SCR1_RESET});
		rdChk("ctrl reset", CTRL_ADDR, {AXI_OKAY, 24'h0, CTRL_RESET});
		rdChk("unmapped", 12'h0f0, {AXI_SLVERR, 32'h0});
		axiWrite(12'h0f0, 32'h0d);
		chkReg("unmapped write resp", {32'h0, AXI_SLVERR}, {32'h0, wResp});
		axiWrite(SCR1_ADDR, 32'h0d);
		chkReg("write resp", {32'h0, AXI_OKAY}, {32'h0, wResp});
		rdChk("scr1 rw", SCR1_ADDR, 34'h0d);
		axiWrite(CTRL_ADDR, 32'h01);
		rdChk("scr1 hidden", SCR1_ADDR, 34'h0);
		axiWrite(SCR1_ADDR, 32'h05);
		axiWrite(CTRL_ADDR, 32'h80);
		axiWrite(SCR1_ADDR, 32'h05);
		chkReg("ignored write resp", {32'h0, AXI_OKAY}, {32'h0, wResp});
		rdChk("scr1 kept", SCR1_ADDR, 34'h0d);
		for (int i = 0; i < 2; i++)
		begin
			axiWrite(CTRL_ADDR, 32'h80);
			{sessionDone, breakNoTrace} <= (i == 0) ? 2'b10 : 2'b01;
			@(posedge clock);
			{sessionDone, breakNoTrace} <= 2'b00;
			repeat (2) @(posedge clock);
			chkState(ST_IDLE);
			rdChk("arm cleared", CTRL_ADDR, 34'h0);
		end
		foreach (route[k])
		begin
			axiWrite(CTRL_ADDR, 32'h0);
			axiWrite(SCR1_ADDR, {28'h0, route[k][15:12]});
			compEnable <= route[k][10:8];
			axiWrite(CTRL_ADDR, 32'h80);
			core_activity_model_inst.pulseMatch(route[k][6:4]);
			@(posedge clock);
			chkState(seq_state_t'(route[k][2:0]));
		end
		rdChk("status", STAT_ADDR, 34'h1);
		// rows are only offered while armed, so every mode write keeps bit 7 set
		axiWrite(CTRL_ADDR, 32'h80);
		emitChk(ev(18'h00080, 8'hc0), row(2'h0, 18'h00080), MASK_A);
		emitChk(ev(18'h00084, 8'h00), '0, MASK_V);
		axiWrite(CTRL_ADDR, 32'h84);
		emitChk(ev(18'h00100, 8'hc0), row(2'h0, 18'h00100), MASK_A);
		emitChk(ev(18'h00100, 8'hc0), '0, MASK_V);
		emitChk(ev(18'h00100, 8'h80), row(2'h0, 18'h00100), MASK_A);
		emitChk(ev(18'h00100, 8'h80), row(2'h0, 18'h00100), MASK_A);
		emitChk(ev(18'h00100, 8'he0), row(2'h0, 18'h00100), MASK_A);
		emitChk(ev(18'h00140, 8'hc0), row(2'h0, 18'h00140), MASK_A);
		emitChk(ev(18'h00200, 8'h00), '0, MASK_V);
		axiWrite(CTRL_ADDR, 32'h88);
		emitChk(ev(18'h00300, 8'h03), row(2'h3, 18'h00300), '1);
		emitChk(ev(18'h00302, 8'h00), row(2'h0, 18'h00302), '1);
		emitChk(ev(18'h00304, 8'h08), '0, MASK_V);
		emitChk(ev(18'h00306, 8'h10), '0, MASK_V);
		axiWrite(CTRL_ADDR, 32'h8c);
		emitChk(ev(18'h01234, 8'h04), row(2'h1, 18'h01234), MASK_I);
		emitChk(ev(18'h01236, 8'h04), row(2'h0, 18'h00036), MASK_I);
		emitChk(ev(18'h01240, 8'h04), row(2'h1, 18'h01240), MASK_I);
		conclude();
	end
endmodule : debug_state1_sequencer_trace_tb
bind debug_state1_sequencer_trace debug_state1_sequencer_trace_checker
	debug_state1_sequencer_trace_checker_inst (.clock(clock), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .matchIn(matchIn), .compEnable(compEnable),
	.sessionDone(sessionDone), .breakNoTrace(breakNoTrace), .busEvent(busEvent),
	.traceRow(traceRow), .seqState(seqState));

// ---- verilog/dbg_seq_pkg.sv ----
// Purpose: shared constants and types for the state1 sequencer and trace formatter
// Assumes: axi4-lite slave with 32-bit data, one register per aligned word
// Notes: offset 0x27 is not a multiple of four, so it is kept as an index
package dbg_seq_pkg;
	localparam logic [7:0] SCR1_INDEX = 8'h27;
	localparam logic [11:0] SCR1_ADDR = {2'h0, SCR1_INDEX, 2'h0};
	localparam logic [7:0] CTRL_INDEX = 8'h20;
	localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
	localparam logic [7:0] STAT_INDEX = 8'h21;
	localparam logic [11:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};
	// control register fields
	localparam int CTRL_ARM_BIT = 7;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_VIEW_LSB = 0;
	localparam logic [3:0] SCR1_RESET = 4'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] VIEW_SCR1 = 2'h0;
	localparam logic [17:0] PAGE_MASK = 18'h3ffc0;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_FLOW, MODE_REPEAT, MODE_DETAIL, MODE_PACKED} trace_mode_t;
	typedef enum {ST_IDLE, ST_ONE, ST_TWO, ST_THREE, ST_FINAL} seq_state_t;

	typedef struct packed {
		logic valid;
		logic [17:0] addr;
		logic [15:0] data;
		logic isFlow;
		logic isSource;
		logic isVector;
		logic isFree;
		logic isFetch;
		logic isOpcode;
		logic isWrite;
		logic isWord;
	} bus_event_t;

	typedef struct packed {
		logic valid;
		logic [1:0] info;
		logic [17:0] addr;
		logic [15:0] data;
	} trace_row_t;
endpackage : dbg_seq_pkg

// ---- verilog/debug_state1_sequencer_trace.sv ----
// Purpose: state1 next-state selection, its control register and trace row formatting
// Assumes: match inputs and bus events come from logic on the same clock
// Notes: trace rows are offered one per cycle with no buffering
// Operation
// - State1 control reads back only while view select is 00.
// - State1 control writes need view select 00 and sequencer disarmed.
// - Four-bit select field picks next state from State1 per match.
// - Code 0000: any enabled match goes to Final State.
// - Codes 0001, 0010, 0011, 1001 route one channel each.
// - Code 0100: match0 to State2, match1 to State3.
// - Code 0101: match1 to State3, match0 to Final State.
// - Code 0110: match0 to State2, match2 to State3.
// - Code 0111: match0 or match1 to State2.
// - Code 1101: match0 or match2 to Final, match1 to State2.
// - Simultaneous matches: Final first, then lowest channel.
// - Code 1101 with match0 and match1 goes to Final.
// - Repeat-filter mode stores change-of-flow addresses only.
// - Each stored address is copied to a background register.
// - Source address equal to previous entry is dropped.
// - Destination and vector addresses are never filtered.
// - Detail mode stores address, data, size and direction.
// - Detail mode skips free and opcode fetch cycles.
// - Packed mode stores PC of every executed opcode, illegal included.
// - Packed mode stores low bits; full PC on the first row and on 64-byte crossing.
// - Packed rows are two info bits plus 18 address bits.
// - View select chooses register at shared address; 00 is State1.
// - Arming enters State1; arm clears on session end or untraced break.
module debug_state1_sequencer_trace
	import dbg_seq_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] matchIn,
	input wire logic [2:0] compEnable,
	input wire logic sessionDone,
	input wire logic breakNoTrace,
	input wire dbg_seq_pkg::bus_event_t busEvent,
	output dbg_seq_pkg::trace_row_t traceRow,
	output dbg_seq_pkg::seq_state_t seqState
);
	import dbg_seq_pkg::*;

	logic [3:0] scr1_reg;
	logic [7:0] ctrl_reg;
	seq_state_t state_reg;
	seq_state_t state_next;
	logic [17:0] background_reg;
	logic bgValid_reg;
	logic [17:0] lastPc_reg;
	logic pcValid_reg;
	trace_row_t row_next;
	logic awHeld_reg;
	logic wHeld_reg;
	logic [11:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic armed;
	logic [1:0] viewSel;
	trace_mode_t mode;
	logic [2:0] hit;
	logic doWrite;
	logic setArm;
	logic ctrlWrite;

	assign armed = ctrl_reg[CTRL_ARM_BIT];
	assign viewSel = ctrl_reg[CTRL_VIEW_LSB +: 2];
	assign mode = trace_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
	// a disabled comparator never reaches the sequencer
	for (genvar c = 0; c < 3; c++)
	begin : maskChannel
		assign hit[c] = matchIn[c] & compEnable[c];
	end

	// next state from state1 for one code; final beats state2/3, then lowest channel
	function automatic seq_state_t pick(input logic [3:0] code, input logic [2:0] m);
		seq_state_t r;
		r = ST_ONE;
		unique case (code)
			4'h0: if (|m) r = ST_FINAL;
			4'h1: if (m[1]) r = ST_THREE;
			4'h2: if (m[2]) r = ST_TWO;
			4'h3: if (m[1]) r = ST_TWO;
			4'h4:
			begin
				if (m[0]) r = ST_TWO;
				else if (m[1]) r = ST_THREE;
			end
			4'h5:
			begin
				if (m[0]) r = ST_FINAL;
				else if (m[1]) r = ST_THREE;
			end
			4'h6:
			begin
				if (m[0]) r = ST_TWO;
				else if (m[2]) r = ST_THREE;
			end
			4'h7: if (m[0] || m[1]) r = ST_TWO;
			4'h9: if (m[0]) r = ST_THREE;
			4'hd:
			begin
				if (m[0] || m[2]) r = ST_FINAL;
				else if (m[1]) r = ST_TWO;
			end
			default: r = ST_ONE;
		endcase
		return r;
	endfunction : pick

	// one decode serves both answer channels so their codes never disagree
	function automatic logic mapped(input logic [11:0] a);
		return a == SCR1_ADDR || a == CTRL_ADDR || a == STAT_ADDR;
	endfunction : mapped

	// write path: address and data accepted in either order, answer after both
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 12'h000;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awAddr_reg) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// a write while armed is dropped silently, the bus still answers okay
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			scr1_reg <= SCR1_RESET;
		else if (doWrite && awAddr_reg == SCR1_ADDR && wStrb_reg[0]
			&& viewSel == VIEW_SCR1 && !armed)
			scr1_reg <= wData_reg[3:0];
	end

	assign ctrlWrite = doWrite && awAddr_reg == CTRL_ADDR && wStrb_reg[0];
	assign setArm = ctrlWrite && wData_reg[CTRL_ARM_BIT];

	// a software set of arm wins over a hardware clear in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_reg <= CTRL_RESET;
		else
		begin
			if (ctrlWrite)
				ctrl_reg <= wData_reg[7:0];
			if ((sessionDone || breakNoTrace) && !setArm)
				ctrl_reg[CTRL_ARM_BIT] <= 1'b0;
		end
	end

	// read path
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr == SCR1_ADDR)
				begin
					// other views belong to registers outside this block
					if (viewSel == VIEW_SCR1)
						s_axi_rdata <= {28'h0000000, scr1_reg};
				end
				else if (s_axi_araddr == CTRL_ADDR)
					s_axi_rdata <= {24'h000000, ctrl_reg};
				else if (s_axi_araddr == STAT_ADDR)
					s_axi_rdata <= {29'h00000000, 3'(state_reg)};
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// sequencer
	always_comb
	begin
		state_next = state_reg;
		if (!armed)
			state_next = ST_IDLE;
		else if (state_reg == ST_IDLE)
			state_next = ST_ONE;
		else if (state_reg == ST_ONE)
			state_next = pick(scr1_reg, hit);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			seqState <= ST_IDLE;
		else
			seqState <= state_next;
	end

	// trace row formatting
	always_comb
	begin
		row_next = '0;
		row_next.addr = busEvent.addr;
		unique case (mode)
			MODE_FLOW:
				row_next.valid = busEvent.valid && busEvent.isFlow;
			MODE_REPEAT:
			begin
				row_next.valid = busEvent.valid && busEvent.isFlow;
				if (busEvent.isSource && !busEvent.isVector && bgValid_reg
					&& background_reg == busEvent.addr)
					row_next.valid = 1'b0;
			end
			MODE_DETAIL:
			begin
				row_next.valid = busEvent.valid && !busEvent.isFree && !busEvent.isFetch;
				row_next.data = busEvent.data;
				row_next.info = {busEvent.isWrite, busEvent.isWord};
			end
			MODE_PACKED:
			begin
				row_next.valid = busEvent.valid && busEvent.isOpcode;
				// info 01 marks the first row or a page crossing, so the full counter follows
				if (!pcValid_reg || ((busEvent.addr ^ lastPc_reg) & PAGE_MASK) != 18'h00000)
					row_next.info = 2'h1;
				else
					row_next.addr = busEvent.addr & ~PAGE_MASK;
			end
		endcase
		if (!armed)
			row_next.valid = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			traceRow <= '0;
		else
			traceRow <= row_next;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			background_reg <= 18'h00000;
			bgValid_reg <= 1'b0;
		end
		else if (row_next.valid && mode == MODE_REPEAT)
		begin
			background_reg <= busEvent.addr;
			bgValid_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lastPc_reg <= 18'h00000;
			pcValid_reg <= 1'b0;
		end
		else if (row_next.valid && mode == MODE_PACKED)
		begin
			lastPc_reg <= busEvent.addr;
			pcValid_reg <= 1'b1;
		end
	end
endmodule : debug_state1_sequencer_trace
